// ### core/rsq_clk_sel.sv
// Purpose: applies option straps to the clock source block
// Assumes: option inputs are stable non-volatile straps
// Notes:   the analog doubler itself is outside; this steers it
`timescale 1ns/1ps
module rsq_clk_sel #(
   parameter int unsigned RANGES = rsq_pkg::RANGE_COUNT
) (
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rst_n,
   input  wire logic                         i_opt_clk_ext,
   input  wire logic [rsq_pkg::RANGE_W-1:0]  i_opt_range,
   input  wire logic                         i_opt_pll_en,
   output logic      [RANGES-1:0]            o_res_en,
   output logic                              o_ext_clk_sel,
   output logic                              o_pll_en,
   output logic                              o_core_tick
);
   logic div_phase;

   // enables ignore reset on purpose so no start-up time follows it
   genvar g;
   generate
      for (g = 0; g < RANGES; g++) begin : g_res
         assign o_res_en[g] = ~i_opt_clk_ext &
            (i_opt_range == rsq_pkg::RANGE_W'(g));
      end
   endgenerate

   assign o_ext_clk_sel = i_opt_clk_ext;
   assign o_pll_en      = i_opt_pll_en;

   // without the doubler the core advances every other oscillator edge
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_phase <= 1'b0;
      end else begin
         div_phase <= ~div_phase;
      end
   end

   assign o_core_tick = i_opt_pll_en | div_phase;
endmodule

// ### core/rsq_pkg.sv
// Purpose: constants and types for the reset sequencer and clock select
// Assumes: one 250 MHz system clock; option bits are stable straps
// Notes:   the watchdog pulse count derives from a time and the clock rate; delay counts are given in cycles
// Overview of operation
// - reset starts from pin, supply detector, watchdog
// - reset pin driven low throughout delay phase
// - phases run active, delay, then vector fetch
// - delay is 256 or 4096 cycles by option
// - vector fetch lasts exactly two clock cycles
// - start address comes from top two bytes
// - multiplier enabled doubles the core clock
// - multiplier disabled divides oscillator clock by two
// - source external or one of five resonators
// - resonators keep running while reset is active
// - low reset pin detected without a clock
// - watchdog underflow drives pin low minimum time
// - pin held low while supply is low
// - disabled supply detector never starts reset
package rsq_pkg;
   localparam int unsigned CLK_MHZ         = 250;
   // minimum watchdog output pulse width, value chosen as a plain default
   localparam int unsigned WDG_MIN_NS      = 500;
   localparam int unsigned WDG_PULSE_CYC   =
      (WDG_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DELAY_SHORT_CYC = 256;
   localparam int unsigned DELAY_LONG_CYC  = 4096;
   localparam int unsigned DELAY_W         = 13;
   localparam int unsigned WDG_W           = 8;
   localparam logic [15:0] VEC_ADDR_LO     = 16'hfffe;
   localparam logic [15:0] VEC_ADDR_HI     = 16'hffff;
   localparam int unsigned RANGE_COUNT     = 5;
   localparam int unsigned RANGE_W         = 3;

   typedef enum logic [1:0] {
      RSQ_ACTIVE,
      RSQ_DELAY,
      RSQ_FETCH,
      RSQ_RUN
   } rsq_state_t;
endpackage

// ### core/rsq_reset_seq.sv
// Purpose: reset sequencer with open-drain reset pin and clock select
// Assumes: option inputs are straps; pin input reads the wire level
// Notes:   the pin reads back low while we drive it, so external
//          pulls during the delay phase are not seen
`timescale 1ns/1ps
module rsq_reset_seq #(
   parameter int unsigned DELAY_SHORT = rsq_pkg::DELAY_SHORT_CYC,
   parameter int unsigned DELAY_LONG  = rsq_pkg::DELAY_LONG_CYC,
   parameter int unsigned WDG_CYC     = rsq_pkg::WDG_PULSE_CYC
) (
   input  wire logic                           i_clk_sys,
   input  wire logic                           i_rst_n,
   input  wire logic                           i_rst_pin_in,
   output logic                                o_rst_pin_out,
   output logic                                o_rst_pin_oe,
   input  wire logic                           i_lsd_low,
   input  wire logic                           i_lsd_enable,
   input  wire logic                           i_wdg_underflow,
   input  wire logic                           i_opt_long_delay,
   input  wire logic                           i_opt_clk_ext,
   input  wire logic [rsq_pkg::RANGE_W-1:0]    i_opt_range,
   input  wire logic                           i_opt_pll_en,
   output logic                                o_core_rst_n,
   output logic                                o_vec_fetch,
   output logic      [15:0]                    o_vec_addr,
   output logic                                o_in_delay,
   output logic      [rsq_pkg::RANGE_COUNT-1:0] o_res_en,
   output logic                                o_ext_clk_sel,
   output logic                                o_pll_en,
   output logic                                o_core_tick
);
   rsq_pkg::rsq_state_t state;
   rsq_pkg::rsq_state_t next_state;

   logic                        pin_seen;
   logic                        pin_clr_n;
   logic [rsq_pkg::WDG_W-1:0]   wdg_cnt;
   logic [rsq_pkg::DELAY_W-1:0] dly_cnt;
   logic [rsq_pkg::DELAY_W-1:0] dly_last;
   logic                        long_sel;
   logic                        next_oe;
   logic [15:0]                 next_addr;
   logic                        lsd_hit;
   logic                        wdg_hit;
   logic                        src_any;
   logic                        dly_done;
   logic                        fetch_second;
   logic                        oe_hold;

   localparam logic [rsq_pkg::DELAY_W-1:0] DLY_SHORT_LAST =
      rsq_pkg::DELAY_W'(DELAY_SHORT - 1);
   localparam logic [rsq_pkg::DELAY_W-1:0] DLY_LONG_LAST =
      rsq_pkg::DELAY_W'(DELAY_LONG - 1);
   localparam logic [rsq_pkg::WDG_W-1:0] WDG_LOAD =
      rsq_pkg::WDG_W'(WDG_CYC);

   // the pin sets this flop without a clock, so halt cannot mask it;
   // our own drive is excluded so the delay phase does not retrigger
   assign pin_clr_n = i_rst_n & (i_rst_pin_in | o_rst_pin_oe | oe_hold);

   always_ff @(posedge i_clk_sys or negedge pin_clr_n) begin
      if (!pin_clr_n) begin
         pin_seen <= 1'b1;
      end else begin
         pin_seen <= 1'b0;
      end
   end

   // the wire rises only after our driver lets go; without one more cycle
   // of mask that release would look like an external pull and re-enter
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_hold <= 1'b0;
      end else begin
         oe_hold <= o_rst_pin_oe;
      end
   end

   // supply detector counts only when its option enables it
   assign lsd_hit = i_lsd_enable & i_lsd_low;
   assign wdg_hit = i_wdg_underflow | (wdg_cnt != '0);
   assign src_any = pin_seen | lsd_hit | wdg_hit;

   assign dly_last = long_sel ? DLY_LONG_LAST : DLY_SHORT_LAST;
   assign dly_done = (dly_cnt == dly_last);

   always_comb begin
      next_state = state;
      unique case (state)
         rsq_pkg::RSQ_ACTIVE: begin
            if (!src_any) begin
               next_state = rsq_pkg::RSQ_DELAY;
            end
         end
         rsq_pkg::RSQ_DELAY: begin
            if (src_any) begin
               next_state = rsq_pkg::RSQ_ACTIVE;
            end else if (dly_done) begin
               next_state = rsq_pkg::RSQ_FETCH;
            end
         end
         rsq_pkg::RSQ_FETCH: begin
            if (src_any) begin
               next_state = rsq_pkg::RSQ_ACTIVE;
            end else if (fetch_second) begin
               next_state = rsq_pkg::RSQ_RUN;
            end
         end
         rsq_pkg::RSQ_RUN: begin
            if (src_any) begin
               next_state = rsq_pkg::RSQ_ACTIVE;
            end
         end
      endcase
   end

   // internal sources pull the pin so that board devices reset too
   assign next_oe = (next_state == rsq_pkg::RSQ_DELAY) |
      ((next_state == rsq_pkg::RSQ_ACTIVE) &
       (lsd_hit | wdg_hit));

   // low address word first, then the high one; held once running
   assign next_addr = (next_state != rsq_pkg::RSQ_FETCH) ? o_vec_addr :
      ((state == rsq_pkg::RSQ_FETCH) ? rsq_pkg::VEC_ADDR_HI
                                     : rsq_pkg::VEC_ADDR_LO);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= rsq_pkg::RSQ_ACTIVE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rst_pin_oe <= 1'b0;
         o_vec_addr   <= rsq_pkg::VEC_ADDR_LO;
      end else begin
         o_rst_pin_oe <= next_oe;
         o_vec_addr   <= next_addr;
      end
   end

   // the underflow is a pulse; stretch it to the minimum pin low time
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wdg_cnt <= '0;
      end else if (i_wdg_underflow) begin
         wdg_cnt <= WDG_LOAD;
      end else if (wdg_cnt != '0) begin
         wdg_cnt <= wdg_cnt - 1'b1;
      end
   end

   // delay length latched on entry so a strap glitch cannot cut it
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         long_sel <= 1'b0;
      end else if (state == rsq_pkg::RSQ_ACTIVE) begin
         long_sel <= i_opt_long_delay;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dly_cnt <= '0;
      end else if (state == rsq_pkg::RSQ_DELAY && !src_any) begin
         dly_cnt <= dly_cnt + 1'b1;
      end else begin
         dly_cnt <= '0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fetch_second <= 1'b0;
      end else begin
         fetch_second <= (state == rsq_pkg::RSQ_FETCH) & ~fetch_second &
                         ~src_any;
      end
   end

   assign o_rst_pin_out = 1'b0;
   assign o_vec_fetch   = (state == rsq_pkg::RSQ_FETCH);
   assign o_in_delay    = (state == rsq_pkg::RSQ_DELAY);
   assign o_core_rst_n  = (state == rsq_pkg::RSQ_RUN) & ~pin_seen;

   rsq_clk_sel #(
      .RANGES (rsq_pkg::RANGE_COUNT)
   ) u_clk_sel (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (i_rst_n),
      .i_opt_clk_ext (i_opt_clk_ext),
      .i_opt_range   (i_opt_range),
      .i_opt_pll_en  (i_opt_pll_en),
      .o_res_en      (o_res_en),
      .o_ext_clk_sel (o_ext_clk_sel),
      .o_pll_en      (o_pll_en),
      .o_core_tick   (o_core_tick)
   );

   // helper: cycles spent in the current delay phase
   logic [rsq_pkg::DELAY_W:0] dly_seen;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dly_seen <= '0;
      end else if (state == rsq_pkg::RSQ_DELAY) begin
         dly_seen <= dly_seen + 1'b1;
      end else begin
         dly_seen <= '0;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   a_pin_in_delay: assert property (
      o_in_delay |-> o_rst_pin_oe)
      else $error("reset pin not driven during delay");

   a_delay_length: assert property (
      (state == rsq_pkg::RSQ_DELAY && next_state == rsq_pkg::RSQ_FETCH)
      |-> (dly_seen == (long_sel ? DELAY_LONG - 1 : DELAY_SHORT - 1)))
      else $error("delay phase length wrong");

   a_fetch_two: assert property (
      ($rose(o_vec_fetch) && !src_any ##1 !src_any)
      |-> o_vec_fetch ##1 (state == rsq_pkg::RSQ_RUN))
      else $error("vector fetch not two cycles");

   a_vector_addr: assert property (
      $rose(o_vec_fetch) |-> (o_vec_addr == rsq_pkg::VEC_ADDR_LO)
      ##1 (!o_vec_fetch || o_vec_addr == rsq_pkg::VEC_ADDR_HI))
      else $error("reset vector address wrong");

   a_phase_order: assert property (
      $rose(o_vec_fetch) |-> $past(state) == rsq_pkg::RSQ_DELAY)
      else $error("fetch not preceded by delay");

   a_source_start: assert property (
      (state == rsq_pkg::RSQ_RUN && (lsd_hit || i_wdg_underflow))
      |=> state == rsq_pkg::RSQ_ACTIVE && !o_core_rst_n)
      else $error("reset source did not start reset");

   a_pin_async: assert property (
      (!i_rst_pin_in && !o_rst_pin_oe) |-> !o_core_rst_n)
      else $error("low pin did not hold core reset");

   a_wdg_pulse: assert property (
      i_wdg_underflow |=> o_rst_pin_oe [*8])
      else $error("watchdog pin pulse too short");

   a_lsd_hold: assert property (
      lsd_hit |=> o_rst_pin_oe && !o_core_rst_n)
      else $error("low supply did not hold pin low");

   a_lsd_disabled: assert property (
      (state == rsq_pkg::RSQ_RUN && !i_lsd_enable && !pin_seen &&
       !wdg_hit) |=> state == rsq_pkg::RSQ_RUN)
      else $error("disabled supply detector caused reset");

   a_delay_restart: assert property (
      (o_in_delay && src_any) |=> state == rsq_pkg::RSQ_ACTIVE
      ##1 (dly_cnt == '0))
      else $error("delay not restarted by new source");

   a_wdg_stretch: assert property (
      wdg_hit |=> o_rst_pin_oe)
      else $error("watchdog stretch released the pin");

   a_delay_entry: assert property (
      $rose(o_in_delay) |-> ($past(state) == rsq_pkg::RSQ_ACTIVE))
      else $error("delay not entered from active phase");

   a_run_released: assert property (
      $rose(o_core_rst_n) |-> $past(o_vec_fetch))
      else $error("core released without vector fetch");

   a_ext_no_res: assert property (
      i_opt_clk_ext |-> (o_res_en == '0))
      else $error("resonator enabled with external clock");

   a_range_onehot: assert property (
      (!i_opt_clk_ext && i_opt_range < rsq_pkg::RANGE_COUNT)
      |-> $onehot(o_res_en))
      else $error("resonator range not one-hot");

   a_tick_halved: assert property (
      (!i_opt_pll_en && !$past(i_opt_pll_en) && $past(i_rst_n))
      |-> (o_core_tick != $past(o_core_tick)))
      else $error("core tick not halved without doubler");

   c_fetch_done: cover property (
      o_vec_fetch ##1 o_vec_fetch ##1 o_core_rst_n);
   c_short_seq: cover property (
      o_in_delay && !long_sel ##[1:300] o_vec_fetch);
   c_wdg_reset: cover property (
      i_wdg_underflow ##[1:600] $rose(o_core_rst_n));
   c_delay_restart: cover property (
      o_in_delay ##1 state == rsq_pkg::RSQ_ACTIVE);
   c_lsd_reset: cover property (
      lsd_hit ##1 o_rst_pin_oe);
endmodule

// ### tb/rsq_board_model.sv
// Purpose: board reset circuitry on the open-drain reset pin
// Assumes: a pull-up on the wire; the bench commands external pulls
// Notes:   a released wire reads high, never the last driven value
`timescale 1ns/1ps
module rsq_board_model (
   input  wire logic i_oe,
   input  wire logic i_out,
   input  wire logic i_pull,
   output logic      o_pin
);
   // wired-and of the device driver and the board switch
   assign o_pin = ((i_oe && !i_out) || i_pull) ? 1'b0 : 1'b1;
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: short counts 8/16/4 stand in for the long ones
// Notes:   inputs change at rising edges, outputs read at falling; the async pin check reads 1 ns after a rising edge
`timescale 1ns/1ps
module tb_top;
   localparam int DS = 8;
   localparam int DL = 16;
   localparam int WC = 4;
   logic       clk, rst_n, pin, pout, poe, pull, lsd, lsd_en, wdg;
   logic       lng, ext, pll, crst_n, vf, indl, ecs, pen, tick, tprev;
   logic [2:0] rng;
   logic [15:0] va;
   logic [4:0] res;
   logic [15:0] exp_q[$];
   int         err_total, comparisons, cyc;
   rsq_reset_seq #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WDG_CYC(WC))
   rsq_reset_seq_i (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_rst_pin_in(pin), .o_rst_pin_out(pout), .o_rst_pin_oe(poe),
      .i_lsd_low(lsd), .i_lsd_enable(lsd_en), .i_wdg_underflow(wdg),
      .i_opt_long_delay(lng), .i_opt_clk_ext(ext), .i_opt_range(rng),
      .i_opt_pll_en(pll), .o_core_rst_n(crst_n), .o_vec_fetch(vf),
      .o_vec_addr(va), .o_in_delay(indl), .o_res_en(res),
      .o_ext_clk_sel(ecs), .o_pll_en(pen), .o_core_tick(tick));
   rsq_board_model rsq_board_model_i (.i_oe(poe), .i_out(pout),
      .i_pull(pull), .o_pin(pin));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp1(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // delay phase length, pin held low, then the two-word fetch
   task automatic seq(input int n);
      int c;
      int k;
      k = 0;
      c = 0;
      while (indl !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      while (indl === 1'b1 && c < 5000) begin
         cmp1(poe, 1'b1);
         cmp1(pout, 1'b0);
         cmp1(crst_n, 1'b0);
         @(negedge clk);
         c++;
      end
      cmp16(16'(c), 16'(n));
      exp_q = {16'hfffe, 16'hffff};
      repeat (2) begin
         cmp1(vf, 1'b1);
         cmp16(va, exp_q.pop_front());
         @(negedge clk);
      end
      cmp1(vf, 1'b0);
      cmp1(crst_n, 1'b1);
   endtask
   task automatic pulse_wdg();
      @(posedge clk);
      wdg <= 1'b1;
      @(posedge clk);
      wdg <= 1'b0;
      @(negedge clk);
      @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      {pull, lsd, lsd_en, wdg, lng, ext, pll} = 7'h00;
      rng = 3'h0;
      rst_n = 1'b0;
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      void'($urandom(32'h40ca));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      seq(DS);
      // watchdog: pin pulled for at least the minimum pulse
      pulse_wdg();
      repeat (WC) begin
         cmp1(poe, 1'b1);
         @(negedge clk);
      end
      seq(DS);
      // external pin pulse, long delay, seen without a clock edge
      @(posedge clk);
      lng <= 1'b1;
      pull <= 1'b1;
      #1;
      cmp1(crst_n, 1'b0);
      repeat (3) @(posedge clk);
      pull <= 1'b0;
      seq(DL);
      // supply low held; clock straps checked while in reset
      @(posedge clk);
      lsd_en <= 1'b1;
      lsd <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rng <= 3'(i);
         ext <= 1'($urandom);
         pll <= 1'($urandom);
         @(negedge clk);
         cmp1(poe, 1'b1);
         cmp1(crst_n, 1'b0);
         cmp16({11'h0, res}, (i < 5 && !ext) ? 16'(1 << i) : 16'h0);
         cmp1(ecs, ext);
         cmp1(pen, pll);
      end
      @(posedge clk);
      lsd <= 1'b0;
      lng <= 1'b0;
      seq(DS);
      // doubler on ticks every cycle, off ticks every other
      @(posedge clk);
      pll <= 1'b1;
      lsd_en <= 1'b0;
      lsd <= 1'b1;
      repeat (4) begin
         @(negedge clk);
         cmp1(tick, 1'b1);
         cmp1(crst_n, 1'b1);
      end
      @(posedge clk);
      pll <= 1'b0;
      @(negedge clk);
      repeat (4) begin
         tprev = tick;
         @(negedge clk);
         cmp1(tick, ~tprev);
         cmp1(crst_n, 1'b1);
      end
      // watchdog in mid-delay restarts the full count
      @(posedge clk);
      lsd <= 1'b0;
      pulse_wdg();
      while (indl !== 1'b1) @(negedge clk);
      repeat (4) @(negedge clk);
      pulse_wdg();
      cmp1(indl, 1'b0);
      seq(DS);
      summarize();
   end
endmodule
